// file: hw/tpec_top.v
// three-channel two-phase event counter with apb register access
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "tpec_consts.vh"

module tpec_top (
  // clock and reset
  input  wire        i_clock,
  input  wire        i_rst,
  // apb slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  // phase and index pins, bit 0 is the third timer channel
  input  wire [2:0]  i_phase_a_input_pin,
  input  wire [2:0]  i_phase_b_input_pin,
  input  wire        i_index_pin,
  // interrupt
  output reg         o_irq
);

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  reg  [2:0]  count_start_flags;
  reg  [7:0]  mode_reg [0:2];
  reg  [2:0]  irq_status;
  reg  [2:0]  irq_mask;
  reg  [2:0]  next_irq_status;
  reg  [31:0] next_rdata;
  reg         next_err;
  reg  [2:0]  read_clear;

  wire        access;
  wire        xfer;
  wire        wr;
  wire        rd_stat;

  wire [6:0]  pin_raw;
  wire [6:0]  pin_level;
  wire [6:0]  pin_rise;
  wire [6:0]  pin_fall;

  wire [47:0] count_flat;
  wire [2:0]  wrap;
  wire [2:0]  count_write;
  wire [2:0]  running;
  wire [2:0]  quad_mode;
  wire [2:0]  z_clear;

  wire        sel_start;
  wire        sel_mode0;
  wire        sel_mode1;
  wire        sel_mode2;
  wire        sel_count0;
  wire        sel_count1;
  wire        sel_count2;
  wire        sel_irq_stat;
  wire        sel_irq_mask;

  // ----------------------------------------------------------------------------
  // register selects
  // ----------------------------------------------------------------------------
  // one compare per register, shared by the write and clear paths
  // unaligned or out-of-range addresses match none and reach the error path
  assign sel_start    = (i_paddr == `TPEC_OFS_START);
  assign sel_mode0    = (i_paddr == `TPEC_OFS_MODE0);
  assign sel_mode1    = (i_paddr == `TPEC_OFS_MODE1);
  assign sel_mode2    = (i_paddr == `TPEC_OFS_MODE2);
  assign sel_count0   = (i_paddr == `TPEC_OFS_COUNT0);
  assign sel_count1   = (i_paddr == `TPEC_OFS_COUNT1);
  assign sel_count2   = (i_paddr == `TPEC_OFS_COUNT2);
  assign sel_irq_stat = (i_paddr == `TPEC_OFS_IRQ_STAT);
  assign sel_irq_mask = (i_paddr == `TPEC_OFS_IRQ_MASK);

  // ----------------------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------------------
  // access samples data a cycle early; xfer commits on the pready edge
  assign access = i_psel & i_penable & ~o_pready;
  assign xfer   = i_psel & i_penable & o_pready;
  assign wr     = xfer & i_pwrite;
  assign rd_stat = xfer & ~i_pwrite & sel_irq_stat;

  always @(posedge i_clock) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= access;
      if (access) begin
        o_prdata  <= i_pwrite ? 32'h0000_0000 : next_rdata;
        o_pslverr <= next_err;
      end else if (xfer) begin
        o_prdata  <= 32'h0000_0000;
        o_pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // read mux and address decode
  // ----------------------------------------------------------------------------
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    case (i_paddr)
      `TPEC_OFS_START: begin
        next_rdata = {29'h0000_0000, count_start_flags};
      end
      `TPEC_OFS_MODE0: begin
        next_rdata = {24'h00_0000, mode_reg[0]};
      end
      `TPEC_OFS_MODE1: begin
        next_rdata = {24'h00_0000, mode_reg[1]};
      end
      `TPEC_OFS_MODE2: begin
        next_rdata = {24'h00_0000, mode_reg[2]};
      end
      `TPEC_OFS_COUNT0: begin
        next_rdata = {16'h0000, count_flat[15:0]};
      end
      `TPEC_OFS_COUNT1: begin
        next_rdata = {16'h0000, count_flat[31:16]};
      end
      `TPEC_OFS_COUNT2: begin
        next_rdata = {16'h0000, count_flat[47:32]};
      end
      `TPEC_OFS_IRQ_STAT: begin
        next_rdata = {29'h0000_0000, irq_status};
      end
      `TPEC_OFS_IRQ_MASK: begin
        next_rdata = {29'h0000_0000, irq_mask};
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // start flags
  // ----------------------------------------------------------------------------
  always @(posedge i_clock) begin
    if (i_rst) begin
      count_start_flags <= `TPEC_RST_FLAGS;
    end else if (wr && sel_start) begin
      // one word for all channels, so they can start on the same edge
      // one starts / zero stops
      count_start_flags <= i_pwdata[2:0];
    end
  end

  // ----------------------------------------------------------------------------
  // mode registers
  // ----------------------------------------------------------------------------
  // method and index bits exist only on the middle channel
  always @(posedge i_clock) begin
    if (i_rst) begin
      mode_reg[0] <= `TPEC_RST_MODE;
      mode_reg[1] <= `TPEC_RST_MODE;
      mode_reg[2] <= `TPEC_RST_MODE;
    end else if (wr) begin
      if (sel_mode0) begin
        mode_reg[0] <= i_pwdata[7:0] & `TPEC_MODE_WMASK;
      end
      if (sel_mode1) begin
        mode_reg[1] <= i_pwdata[7:0] & `TPEC_MODE_WMASK_SEL;
      end
      if (sel_mode2) begin
        mode_reg[2] <= i_pwdata[7:0] & `TPEC_MODE_WMASK;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // count register writes
  // ----------------------------------------------------------------------------
  // running write only reaches reload
  // the same bus word feeds reload and counter alike
  assign count_write[0] = wr & sel_count0;
  assign count_write[1] = wr & sel_count1;
  assign count_write[2] = wr & sel_count2;

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  // both pins of a channel are phase inputs
  assign pin_raw = {i_index_pin, i_phase_b_input_pin, i_phase_a_input_pin};

  // one shared synchroniser for all pins
  tpec_sync_edge #(
    .WIDTH (7)
  ) u_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async (pin_raw),
    .o_level (pin_level),
    .o_rise  (pin_rise),
    .o_fall  (pin_fall)
  );

  // ----------------------------------------------------------------------------
  // counter channels
  // ----------------------------------------------------------------------------
  // fixed normal, selectable, fixed quad
  // only the middle channel reads its method bit
  assign quad_mode[0] = 1'b0;
  assign quad_mode[1] = mode_reg[1][`TPEC_MODE_QUAD];
  assign quad_mode[2] = 1'b1;

  // index clear on middle channel
  // clear ignores the run bit, so a stopped axis can still be homed
  assign z_clear[0] = 1'b0;
  assign z_clear[1] = mode_reg[1][`TPEC_MODE_INDEX] & pin_rise[6]
                      & (mode_reg[1][1:0] == `TPEC_OP_EVENT);
  assign z_clear[2] = 1'b0;

  assign running[0] = count_start_flags[0]
                      & (mode_reg[0][1:0] == `TPEC_OP_EVENT)
                      & ~mode_reg[0][`TPEC_MODE_PULSE];
  assign running[1] = count_start_flags[1]
                      & (mode_reg[1][1:0] == `TPEC_OP_EVENT)
                      & ~mode_reg[1][`TPEC_MODE_PULSE];
  assign running[2] = count_start_flags[2]
                      & (mode_reg[2][1:0] == `TPEC_OP_EVENT)
                      & ~mode_reg[2][`TPEC_MODE_PULSE];

  // ----------------------------------------------------------------------------
  // channel instances
  // ----------------------------------------------------------------------------
  // third timer channel, normal processing only
  tpec_channel u_ch0 (
    .i_clock    (i_clock),
    .i_rst      (i_rst),
    .i_enable   (running[0]),
    .i_quad     (quad_mode[0]),
    .i_free_run (mode_reg[0][`TPEC_MODE_FREE]),
    .i_z_clear  (z_clear[0]),
    .i_a_rise   (pin_rise[0]),
    .i_a_fall   (pin_fall[0]),
    .i_b_rise   (pin_rise[3]),
    .i_b_fall   (pin_fall[3]),
    .i_b_level  (pin_level[3]),
    .i_write    (count_write[0]),
    .i_wdata    (i_pwdata[15:0]),
    .o_count    (count_flat[15:0]),
    .o_wrap     (wrap[0])
  );

  // fourth timer channel, method chosen by software, sole user of the index pin
  tpec_channel u_ch1 (
    .i_clock    (i_clock),
    .i_rst      (i_rst),
    .i_enable   (running[1]),
    .i_quad     (quad_mode[1]),
    .i_free_run (mode_reg[1][`TPEC_MODE_FREE]),
    .i_z_clear  (z_clear[1]),
    .i_a_rise   (pin_rise[1]),
    .i_a_fall   (pin_fall[1]),
    .i_b_rise   (pin_rise[4]),
    .i_b_fall   (pin_fall[4]),
    .i_b_level  (pin_level[4]),
    .i_write    (count_write[1]),
    .i_wdata    (i_pwdata[15:0]),
    .o_count    (count_flat[31:16]),
    .o_wrap     (wrap[1])
  );

  // fifth timer channel, multiply-by-4 only
  tpec_channel u_ch2 (
    .i_clock    (i_clock),
    .i_rst      (i_rst),
    .i_enable   (running[2]),
    .i_quad     (quad_mode[2]),
    .i_free_run (mode_reg[2][`TPEC_MODE_FREE]),
    .i_z_clear  (z_clear[2]),
    .i_a_rise   (pin_rise[2]),
    .i_a_fall   (pin_fall[2]),
    .i_b_rise   (pin_rise[5]),
    .i_b_fall   (pin_fall[5]),
    .i_b_level  (pin_level[5]),
    .i_write    (count_write[2]),
    .i_wdata    (i_pwdata[15:0]),
    .o_count    (count_flat[47:32]),
    .o_wrap     (wrap[2])
  );

  // ----------------------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------------------
  // only bits shown to the reader are cleared, so a late event survives
  always @* begin
    read_clear      = rd_stat ? o_prdata[2:0] : 3'h0;
    // wrap sets sticky flag, set wins
    next_irq_status = (irq_status & ~read_clear) | wrap;
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      irq_status <= `TPEC_RST_FLAGS;
      irq_mask   <= `TPEC_RST_FLAGS;
      o_irq      <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      // a new mask reaches the line one edge after it is written
      if (wr && sel_irq_mask) begin
        irq_mask <= i_pwdata[2:0];
      end
      // registered from next_irq_status, so the line changes on the same edge as the status flag
      o_irq <= |(next_irq_status & irq_mask);
    end
  end

endmodule

// file: hw/tpec_consts.vh
// register map, field positions, reset values and codes of the event counter
`ifndef TPEC_CONSTS_VH
`define TPEC_CONSTS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define TPEC_OFS_START      8'h00
`define TPEC_OFS_MODE0      8'h04
`define TPEC_OFS_MODE1      8'h08
`define TPEC_OFS_MODE2      8'h0C
`define TPEC_OFS_COUNT0     8'h10
`define TPEC_OFS_COUNT1     8'h14
`define TPEC_OFS_COUNT2     8'h18
`define TPEC_OFS_IRQ_STAT   8'h1C
`define TPEC_OFS_IRQ_MASK   8'h20

// ----------------------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------------------
`define TPEC_MODE_OP_LO     0
`define TPEC_MODE_OP_HI     1
`define TPEC_MODE_PULSE     2
`define TPEC_MODE_FREE      3
`define TPEC_MODE_QUAD      4
`define TPEC_MODE_INDEX     5
`define TPEC_MODE_WMASK     8'h0F
`define TPEC_MODE_WMASK_SEL 8'h3F
`define TPEC_OP_EVENT       2'h1

// ----------------------------------------------------------------------------
// channel positions and reset values
// ----------------------------------------------------------------------------
`define TPEC_CH_NORMAL      0
`define TPEC_CH_SELECT      1
`define TPEC_CH_QUAD        2
`define TPEC_RST_MODE       8'h00
`define TPEC_RST_COUNT      16'h0000
`define TPEC_RST_FLAGS      3'h0
`define TPEC_COUNT_MAX      16'hFFFF
`define TPEC_COUNT_MIN      16'h0000

`endif

// file: hw/tpec_sync_edge.v
// two-stage input synchroniser with edge detection after the second stage
`timescale 1ns/100ps

module tpec_sync_edge #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             i_clock,
  input  wire             i_rst,
  // raw pins
  input  wire [WIDTH-1:0] i_async,
  // synchronised level and edges
  output wire [WIDTH-1:0] o_level,
  output wire [WIDTH-1:0] o_rise,
  output wire [WIDTH-1:0] o_fall
);

  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] sync;
  reg [WIDTH-1:0] prev;

  // ----------------------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------------------
  // sync then detect edges
  always @(posedge i_clock) begin
    if (i_rst) begin
      meta <= {WIDTH{1'b0}};
      sync <= {WIDTH{1'b0}};
      prev <= {WIDTH{1'b0}};
    end else begin
      meta <= i_async;
      sync <= meta;
      prev <= sync;
    end
  end

  // edges only from the settled stages, never from meta
  assign o_level = sync;
  assign o_rise  = sync & ~prev;
  assign o_fall  = ~sync & prev;

endmodule

// file: hw/tpec_channel.v
// one 16-bit reloadable up/down counter fed by decoded phase edges
`timescale 1ns/100ps
`include "tpec_consts.vh"

module tpec_channel (
  // clock and reset
  input  wire        i_clock,
  input  wire        i_rst,
  // control
  input  wire        i_enable,
  input  wire        i_quad,
  input  wire        i_free_run,
  input  wire        i_z_clear,
  // phase edges
  input  wire        i_a_rise,
  input  wire        i_a_fall,
  input  wire        i_b_rise,
  input  wire        i_b_fall,
  input  wire        i_b_level,
  // software write
  input  wire        i_write,
  input  wire [15:0] i_wdata,
  // state
  output reg  [15:0] o_count,
  output reg         o_wrap
);

  reg  [15:0] reload;
  reg         dir_up;
  reg         next_dir_up;
  reg         step;
  reg         up;

  // ----------------------------------------------------------------------------
  // edge decode
  // ----------------------------------------------------------------------------
  always @* begin
    next_dir_up = dir_up;
    if (i_a_rise && i_b_level) next_dir_up = 1'b1;
    if (i_a_fall && i_b_level) next_dir_up = 1'b0;
    if (i_quad) begin
      step = i_a_rise | i_a_fall | i_b_rise | i_b_fall;
      up   = next_dir_up;
    end else begin
      step = (i_a_rise | i_a_fall) & i_b_level;
      up   = i_a_rise;
    end
  end

  // ----------------------------------------------------------------------------
  // counter and reload
  // ----------------------------------------------------------------------------
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_count <= `TPEC_RST_COUNT;
      reload  <= `TPEC_RST_COUNT;
      dir_up  <= 1'b1;
      o_wrap  <= 1'b0;
    end else begin
      o_wrap <= 1'b0;
      dir_up <= next_dir_up;
      if (i_write) begin
        reload <= i_wdata;
        if (!i_enable) o_count <= i_wdata;
      end
      if (i_z_clear) begin
        o_count <= `TPEC_COUNT_MIN;
      end else if (i_enable && step) begin
        if (up && o_count == `TPEC_COUNT_MAX) begin
          o_wrap  <= 1'b1;
          // reload and keep counting / free-run wraps
          o_count <= i_free_run ? `TPEC_COUNT_MIN : reload;
        end else if (!up && o_count == `TPEC_COUNT_MIN) begin
          o_wrap  <= 1'b1;
          o_count <= i_free_run ? `TPEC_COUNT_MAX : reload;
        end else if (up) begin
          o_count <= o_count + 16'h0001;
        end else begin
          o_count <= o_count - 16'h0001;
        end
      end
    end
  end

endmodule

// file: verification/tpec_top_properties.sv
// apb and interrupt checker for the event counter top
`timescale 1ns/100ps

module tpec_top_checker (
  // clock and reset
  input wire        i_clock,
  input wire        i_rst,
  // apb
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [7:0]  i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_pslverr,
  // interrupt
  input wire        o_irq
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire map_ok = (i_paddr <= 8'h20) && (i_paddr[1:0] == 2'h0);
  sequence s_wait;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_mask_off;
    s_wait ##1 o_pready && i_pwrite && i_paddr == 8'h20 && i_pwdata[2:0] == 3'h0;
  endsequence
  a_pready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready held too long");
  a_pready_wait: assert property (s_wait |=> o_pready)
    else $error("pready late");
  a_pready_cause: assert property (o_pready |-> $past(i_psel && i_penable))
    else $error("pready without access");
  a_err_unmapped: assert property (o_pready && !map_ok |-> o_pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (o_pready && map_ok |-> !o_pslverr)
    else $error("mapped access refused");
  a_err_alone: assert property (o_pslverr |-> o_pready)
    else $error("pslverr outside answer");
  a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside answer");
  a_err_rdzero: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
    else $error("refused read not zero");
  a_irq_masked: assert property (s_mask_off |-> ##2 !o_irq)
    else $error("irq while all masked");
endmodule

bind tpec_top tpec_top_checker i_tpec_top_checker (
  .i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq));

// file: verification/tpec_encoder.sv
// quadrature encoder and index source facing the counter pins
`timescale 1ns/100ps

module tpec_encoder (
  // clock
  input  wire       i_clock,
  // phase and index pins
  output reg  [2:0] o_a,
  output reg  [2:0] o_b,
  output reg        o_z
);
  initial begin
    o_a = 3'h0;
    o_b = 3'h0;
    o_z = 1'b0;
  end
  // levels held long enough for the sampler
  task automatic hold();
    repeat (4) @(posedge i_clock);
  endtask
  // two pins, b leads going up
  task automatic step(input int ch, input bit up);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clock);
      if (up ^ k[0]) o_b[ch] <= ~o_b[ch];
      else o_a[ch] <= ~o_a[ch];
      hold();
    end
  endtask
  task automatic index_pulse();
    @(posedge i_clock);
    o_z <= 1'b1;
    hold();
    o_z <= 1'b0;
    hold();
  endtask
endmodule

// file: verification/two_phase_event_counter_tb.sv
// self-checking bench of the two-phase event counter
`timescale 1ns/100ps

module two_phase_event_counter_tb;
  // ----
  // signals and model
  // ----
  logic        i_clock = 1'b0, i_rst = 1'b1;
  logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0000_0000, rdat;
  wire  [31:0] o_prdata;
  wire         o_pready, o_pslverr, o_irq, pz;
  wire  [2:0]  pa, pb;
  logic        rerr;
  logic [2:0]  run = 3'h0, irq_st = 3'h0, free = 3'h0;
  int          n_mismatch = 0, checks_done = 0, seed = 38370, cnt[3], rel[3], base;

  always #10 i_clock = ~i_clock;

  tpec_top i_tpec_top (.i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_phase_a_input_pin(pa), .i_phase_b_input_pin(pb), .i_index_pin(pz), .o_irq(o_irq));
  tpec_encoder i_tpec_encoder (.i_clock(i_clock), .o_a(pa), .o_b(pb), .o_z(pz));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // master holds the request until pready, no fixed latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
    @(posedge i_clock);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    rdat = o_prdata;
    rerr = o_pslverr;
    {i_psel, i_penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask
  task automatic wcnt(input int c, input logic [15:0] d);
    wr(8'h10 + 4 * c, d);
    rel[c] = d;
    if (!run[c]) cnt[c] = d;
  endtask
  task automatic setrun(input logic [2:0] r);
    wr(8'h00, r);
    run = r;
  endtask
  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    check(o_irq, exp);
  endtask
  task automatic ev(input int c, input bit up);
    if (up && cnt[c] == 16'hFFFF || !up && cnt[c] == 0) begin
      cnt[c] = free[c] ? (up ? 0 : 16'hFFFF) : rel[c];
      irq_st[c] = 1'b1;
    end else cnt[c] = up ? cnt[c] + 1 : cnt[c] - 1;
  endtask
  task automatic mv(input int c, input bit up, input int k);
    repeat (k) begin
      i_tpec_encoder.step(c, up);
      if (run[c]) repeat (c == 0 ? 1 : 4) ev(c, up);
    end
  endtask

  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(8'h10, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    check(rerr, 1'b1);
    $display("test reset done");
    wr(8'h04, 32'h1);
    wcnt(0, 16'h0005);
    rd(8'h10, cnt[0]);
    setrun(3'h1);
    mv(0, 1, 3);
    rd(8'h10, cnt[0]);
    mv(0, 0, 1);
    rd(8'h10, cnt[0]);
    wcnt(0, 16'h0002);
    rd(8'h10, cnt[0]);
    wr(8'h20, 32'h1);
    mv(0, 0, 8);
    rd(8'h10, cnt[0]);
    chk_irq(1'b1);
    wr(8'h20, 32'h0);
    chk_irq(1'b0);
    wr(8'h20, 32'h1);
    rd(8'h1C, irq_st);
    irq_st = 3'h0;
    chk_irq(1'b0);
    $display("test normal done");
    setrun(3'h0);
    wr(8'h04, 32'h9);
    free[0] = 1'b1;
    wcnt(0, 16'h0000);
    setrun(3'h1);
    mv(0, 0, 1);
    rd(8'h10, cnt[0]);
    mv(0, 1, 1);
    rd(8'h10, cnt[0]);
    setrun(3'h0);
    mv(0, 1, 2);
    rd(8'h10, cnt[0]);
    // software keeps pulse select clear; once set, the channel must hold
    wr(8'h04, 32'h5);
    setrun(3'h1);
    run = 3'h0;
    mv(0, 1, 2);
    rd(8'h10, cnt[0]);
    setrun(3'h0);
    wr(8'h04, 32'h1);
    free[0] = 1'b0;
    wcnt(0, $random(seed));
    rd(8'h10, cnt[0]);
    wcnt(0, 16'hFFFD);
    setrun(3'h1);
    mv(0, 1, 3);
    rd(8'h10, cnt[0]);
    rd(8'h1C, irq_st);
    irq_st = 3'h0;
    $display("test wrap done");
    wr(8'h0C, 32'h1);
    setrun(3'h4);
    mv(2, 1, 2);
    rd(8'h18, cnt[2]);
    i_tpec_encoder.step(2, 1'b0);
    apb(1'b0, 8'h18, 32'h0);
    base = rdat;
    i_tpec_encoder.step(2, 1'b0);
    rd(8'h18, (base - 4) & 16'hFFFF);
    wr(8'h04, 32'h11);
    rd(8'h04, 32'h1);
    wr(8'h08, 32'h31);
    rd(8'h08, 32'h31);
    wcnt(1, 16'h0009);
    i_tpec_encoder.index_pulse();
    rd(8'h14, 32'h0);
    cnt[1] = 0;
    setrun(3'h2);
    mv(1, 1, 1);
    rd(8'h14, cnt[1]);
    wr(8'h08, 32'h1);
    i_tpec_encoder.step(1, 1'b1);
    cnt[1] = cnt[1] + 1;
    rd(8'h14, cnt[1]);
    $display("test quad done");
    report_and_stop();
  end
endmodule
